// ---- swmp_pkg.sv ----
/*
  Constants, field positions, timing counts and state encodings of the single-wire
  monitor port. Assumes a bus clock on which one serial bit lasts a fixed number of cycles.
*/
package swmp_pkg;

	// ------------------------------------------------------------
	// Bit timing, counted in bus clock cycles and in bit periods
	// ------------------------------------------------------------
	localparam logic [9:0] BIT_CYC     = 10'h100;
	// Alternative period chosen by the baud select pin at a high-voltage entry; the value is a plain default.
	localparam logic [9:0] BIT_CYC_ALT = 10'h200;
	localparam logic [3:0] GAP_BITS    = 4'h2;
	localparam logic [3:0] BRK_HI_BITS = 4'h2;
	localparam logic [3:0] BRK_BITS    = 4'hA;
	localparam logic [3:0] CHAR_BITS   = 4'hA;
	localparam logic [3:0] DATA_BITS   = 4'h8;
	localparam logic [3:0] DLY_BITS    = 4'hB;

	// ------------------------------------------------------------
	// Vector relocation
	// ------------------------------------------------------------
	localparam logic [7:0] VEC_USER_PAGE = 8'hFF;
	localparam logic [7:0] VEC_MON_PAGE  = 8'hFE;
	localparam logic [5:0] VEC_LOW_TOP   = 6'h3F;

	// ------------------------------------------------------------
	// Security
	// ------------------------------------------------------------
	localparam logic [15:0] SEC_BASE      = 16'hFFF6;
	localparam logic [2:0]  SEC_LAST      = 3'h7;
	localparam logic [15:0] SEC_RAM_ADDR  = 16'h0040;
	localparam logic [2:0]  SEC_RAM_BIT   = 3'h6;
	localparam logic [7:0]  FLASH_INVALID = 8'h00;

	// ------------------------------------------------------------
	// Command codes, plain defaults
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ   = 8'h01;
	localparam logic [7:0] CMD_WRITE  = 8'h02;
	localparam logic [7:0] CMD_INDEXED_READ_CMD  = 8'h03;
	localparam logic [7:0] CMD_INDEXED_WRITE_CMD = 8'h04;
	localparam logic [7:0] CMD_STACK_POINTER_READ_CMD = 8'h05;
	localparam logic [7:0] CMD_RUN    = 8'h06;

	// ------------------------------------------------------------
	// Stack frame at entry, offsets above the stack pointer
	// ------------------------------------------------------------
	localparam logic [15:0] SP_OFS_XH  = 16'h0001;
	localparam logic [15:0] SP_OFS_CCR = 16'h0002;
	localparam logic [15:0] SP_OFS_ACC = 16'h0003;
	localparam logic [15:0] SP_OFS_XL  = 16'h0004;
	localparam logic [15:0] SP_OFS_PCH = 16'h0005;
	localparam logic [15:0] SP_OFS_PCL = 16'h0006;

	// ------------------------------------------------------------
	// Transmit queue and state encodings
	// ------------------------------------------------------------
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b11, RX_WAITHI = 2'b10
	} swmp_rx_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000, TX_GAP = 3'b001, TX_SHIFT = 3'b011,
		TX_BRKHI = 3'b010, TX_BRK = 3'b110
	} swmp_tx_t;

	typedef enum logic [2:0] {
		C_OFF = 3'b000, C_SEC = 3'b001, C_CMD = 3'b011, C_ARG = 3'b010,
		C_DLY = 3'b110, C_EXEC = 3'b111, C_MEM = 3'b101, C_SECW = 3'b100
	} swmp_ctl_t;

endpackage

// ---- swmp_top.sv ----
/*
  Single-wire monitor port: entry latch, vector relocation, serial receiver and
  transmitter on one wired-OR pin, a transmit queue, the command engine and the
  security check. Assumes a memory port with one cycle of read latency, a CPU that
  performs the entry and run stack sequences when pulsed, and an external pull-up.
*/
`timescale 1ns/1ns

// ------------------------------------------------------------
// Transmit queue
// ------------------------------------------------------------
module swmp_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	input  wire logic         clr_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_q [D];
	logic [AW:0]  wp_q;
	logic [AW:0]  wp_d;
	logic [AW:0]  rp_q;
	logic [AW:0]  rp_d;
	logic         push;
	logic         pop;

	// The extra pointer bit tells full from empty without a counter.
	assign in_ready_out  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign out_valid_out = (wp_q != rp_q);
	assign out_data_out  = mem_q[rp_q[AW-1:0]];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_comb begin
		wp_d = wp_q;
		rp_d = rp_q;
		if (clr_in) begin
			wp_d = '0;
			rp_d = '0;
		end else begin
			if (push) begin
				wp_d = wp_q + 1'b1;
			end
			if (pop) begin
				rp_d = rp_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem_q[wp_q[AW-1:0]] <= in_data_in;
		end
	end
endmodule

// ------------------------------------------------------------
// Monitor port top
// ------------------------------------------------------------
module swmp_top
	import swmp_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        user_reset_in,
	input  wire logic        ext_reset_n_in,
	input  wire logic        test_high_voltage_in,
	input  wire logic        reset_vec_blank_in,
	input  wire logic        baud_select_pin_in,
	input  wire logic        serial_comm_pin_in,
	output logic             serial_comm_pin_out,
	output logic             serial_comm_pin_oe_out,
	output logic [15:0]      mem_addr_out,
	output logic [7:0]       mem_wdata_out,
	output logic             mem_rd_out,
	output logic             mem_wr_out,
	input  wire logic [7:0]  mem_rdata_in,
	input  wire logic        mem_is_flash_in,
	input  wire logic [15:0] cpu_sp_in,
	input  wire logic [15:0] vec_addr_in,
	output logic [15:0]      vec_addr_out,
	input  wire logic        exec_flash_in,
	output logic             illegal_reset_out,
	output logic             entry_swi_out,
	output logic             run_out,
	output logic             monitor_mode_out,
	output logic             forced_div4_out,
	output logic             sec_bypass_out
);
	function automatic logic [9:0] bit_len_f(input logic sel);
		return sel ? (BIT_CYC_ALT - 10'h001) : (BIT_CYC - 10'h001);
	endfunction

	// Entry and security state.
	logic        mon_q, mon_d, forced_q, forced_d, baud_q, baud_d;
	logic        por_pend_q, por_pend_d, rstn_prev_q, rstn_prev_d;
	logic        sec_ok_q, sec_ok_d, match_q, match_d;
	logic [2:0]  sec_idx_q, sec_idx_d;
	logic        entry_q, entry_d, run_q, run_d, illegal_q, illegal_d;
	logic [15:0] vec_q, vec_d;
	// Receiver.
	swmp_rx_t    rx_st_q, rx_st_d;
	logic [9:0]  rx_cnt_q, rx_cnt_d;
	logic [3:0]  rx_bit_q, rx_bit_d;
	logic [8:0]  rx_sh_q, rx_sh_d;
	logic [7:0]  rx_data_q, rx_data_d;
	logic        rx_done_q, rx_done_d, rx_brk_q, rx_brk_d;
	// Transmitter.
	swmp_tx_t    tx_st_q, tx_st_d;
	logic [9:0]  tx_cnt_q, tx_cnt_d;
	logic [3:0]  tx_bits_q, tx_bits_d;
	logic [9:0]  tx_sh_q, tx_sh_d;
	logic        tx_low_q, tx_low_d, brk_ack, tx_busy;
	// Command engine.
	swmp_ctl_t   ctl_st_q, ctl_st_d;
	logic [7:0]  cmd_q, cmd_d, wdat_q, wdat_d, hold_q, hold_d;
	logic [1:0]  argn_q, argn_d, cnt_q, cnt_d, step_q, step_d;
	logic [15:0] addr_q, addr_d, maddr_q, maddr_d;
	logic [7:0]  mwdata_q, mwdata_d;
	logic        mrd_q, mrd_d, mwr_q, mwr_d, rd_pend_q, rd_pend_d;
	logic [9:0]  dly_cnt_q, dly_cnt_d;
	logic [3:0]  dly_bits_q, dly_bits_d;
	logic        brk_req_q, brk_req_d, brk_set;
	// Queue ports.
	logic        push_v, fifo_in_rdy, fifo_out_v, fifo_out_rdy;
	logic [7:0]  push_data, fifo_out_data, rdata_vis;
	logic [15:0] sp_plus1;

	assign serial_comm_pin_out    = 1'b0;
	assign serial_comm_pin_oe_out = tx_low_q;
	assign mem_addr_out           = maddr_q;
	assign mem_wdata_out          = mwdata_q;
	assign mem_rd_out             = mrd_q;
	assign mem_wr_out             = mwr_q;
	assign vec_addr_out           = vec_q;
	assign illegal_reset_out      = illegal_q;
	assign entry_swi_out          = entry_q;
	assign run_out                = run_q;
	assign monitor_mode_out       = mon_q;
	assign forced_div4_out        = forced_q;
	assign sec_bypass_out         = sec_ok_q;
	assign tx_busy                = (tx_st_q != TX_IDLE);
	assign fifo_out_rdy           = (tx_st_q == TX_IDLE) && !brk_req_q;
	assign rdata_vis = (!sec_ok_q && mem_is_flash_in) ? FLASH_INVALID : mem_rdata_in;
	assign sp_plus1  = cpu_sp_in + SP_OFS_XH;

	swmp_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) u_fifo (
		.mclk_in       (mclk_in),
		.rst_in        (rst_in),
		.clr_in        (user_reset_in),
		.in_valid_in   (push_v),
		.in_ready_out  (fifo_in_rdy),
		.in_data_in    (push_data),
		.out_valid_out (fifo_out_v),
		.out_ready_in  (fifo_out_rdy),
		.out_data_out  (fifo_out_data)
	);

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	// The pin is shared with our own transmitter, so reception is shut while we send.
	always_comb begin
		rx_st_d   = rx_st_q;
		rx_cnt_d  = rx_cnt_q;
		rx_bit_d  = rx_bit_q;
		rx_sh_d   = rx_sh_q;
		rx_data_d = rx_data_q;
		rx_done_d = 1'b0;
		rx_brk_d  = 1'b0;
		case (rx_st_q)
			RX_IDLE: begin
				if (!tx_busy && !serial_comm_pin_in) begin
					rx_st_d  = RX_START;
					rx_cnt_d = bit_len_f(baud_q) >> 1;
				end
			end
			RX_START: begin
				if (rx_cnt_q != 10'h000) begin
					rx_cnt_d = rx_cnt_q - 10'h001;
				end else if (!serial_comm_pin_in) begin
					rx_st_d  = RX_BITS;
					rx_cnt_d = bit_len_f(baud_q);
					rx_bit_d = 4'h0;
				end else begin
					rx_st_d = RX_IDLE;
				end
			end
			RX_BITS: begin
				if (rx_cnt_q != 10'h000) begin
					rx_cnt_d = rx_cnt_q - 10'h001;
				end else begin
					rx_sh_d  = {serial_comm_pin_in, rx_sh_q[8:1]};
					rx_bit_d = rx_bit_q + 4'h1;
					rx_cnt_d = bit_len_f(baud_q);
					if (rx_bit_q == DATA_BITS) begin
						if (serial_comm_pin_in) begin
							rx_done_d = 1'b1;
							rx_data_d = rx_sh_d[7:0];
							rx_st_d   = RX_IDLE;
						end else begin
							rx_brk_d = (rx_sh_d[7:0] == 8'h00);
							rx_st_d  = RX_WAITHI;
						end
					end
				end
			end
			RX_WAITHI: begin
				if (serial_comm_pin_in) begin
					rx_st_d = RX_IDLE;
				end
			end
			default: rx_st_d = RX_IDLE;
		endcase
		if (user_reset_in) begin
			rx_st_d = RX_IDLE;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_st_q   <= RX_IDLE;
			rx_cnt_q  <= '0;
			rx_bit_q  <= '0;
			rx_sh_q   <= '0;
			rx_data_q <= '0;
			rx_done_q <= 1'b0;
			rx_brk_q  <= 1'b0;
		end else begin
			rx_st_q   <= rx_st_d;
			rx_cnt_q  <= rx_cnt_d;
			rx_bit_q  <= rx_bit_d;
			rx_sh_q   <= rx_sh_d;
			rx_data_q <= rx_data_d;
			rx_done_q <= rx_done_d;
			rx_brk_q  <= rx_brk_d;
		end
	end

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	always_comb begin
		tx_st_d   = tx_st_q;
		tx_cnt_d  = tx_cnt_q;
		tx_bits_d = tx_bits_q;
		tx_sh_d   = tx_sh_q;
		tx_low_d  = tx_low_q;
		brk_ack   = 1'b0;
		if (tx_st_q == TX_IDLE) begin
			tx_low_d = 1'b0;
			tx_cnt_d = bit_len_f(baud_q);
			if (brk_req_q) begin
				brk_ack   = 1'b1;
				tx_st_d   = TX_BRKHI;
				tx_bits_d = BRK_HI_BITS;
			end else if (fifo_out_v) begin
				tx_sh_d   = {1'b1, fifo_out_data, 1'b0};
				tx_st_d   = TX_GAP;
				tx_bits_d = GAP_BITS;
			end
		end else if (tx_cnt_q != 10'h000) begin
			tx_cnt_d = tx_cnt_q - 10'h001;
		end else begin
			tx_cnt_d  = bit_len_f(baud_q);
			tx_bits_d = tx_bits_q - 4'h1;
			case (tx_st_q)
				TX_GAP: begin
					if (tx_bits_q == 4'h1) begin
						tx_st_d   = TX_SHIFT;
						tx_bits_d = CHAR_BITS;
						tx_low_d  = !tx_sh_q[0];
					end
				end
				TX_SHIFT: begin
					tx_sh_d  = {1'b1, tx_sh_q[9:1]};
					tx_low_d = !tx_sh_d[0];
					if (tx_bits_q == 4'h1) begin
						tx_st_d  = TX_IDLE;
						tx_low_d = 1'b0;
					end
				end
				TX_BRKHI: begin
					if (tx_bits_q == 4'h1) begin
						tx_st_d   = TX_BRK;
						tx_bits_d = BRK_BITS;
						tx_low_d  = 1'b1;
					end
				end
				TX_BRK: begin
					if (tx_bits_q == 4'h1) begin
						tx_st_d  = TX_IDLE;
						tx_low_d = 1'b0;
					end
				end
				default: tx_st_d = TX_IDLE;
			endcase
		end
		if (user_reset_in) begin
			tx_st_d  = TX_IDLE;
			tx_low_d = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_st_q   <= TX_IDLE;
			tx_cnt_q  <= '0;
			tx_bits_q <= '0;
			tx_sh_q   <= '0;
			tx_low_q  <= 1'b0;
		end else begin
			tx_st_q   <= tx_st_d;
			tx_cnt_q  <= tx_cnt_d;
			tx_bits_q <= tx_bits_d;
			tx_sh_q   <= tx_sh_d;
			tx_low_q  <= tx_low_d;
		end
	end

	// ------------------------------------------------------------
	// Entry, security and command engine
	// ------------------------------------------------------------
	always_comb begin
		mon_d = mon_q;  forced_d = forced_q;  baud_d = baud_q;
		por_pend_d  = por_pend_q;
		rstn_prev_d = ext_reset_n_in;
		sec_ok_d = sec_ok_q;  match_d = match_q;  sec_idx_d = sec_idx_q;
		ctl_st_d = ctl_st_q;  cmd_d = cmd_q;  wdat_d = wdat_q;  hold_d = hold_q;
		argn_d = argn_q;  cnt_d = cnt_q;  step_d = step_q;  addr_d = addr_q;
		maddr_d = maddr_q;  mwdata_d = mwdata_q;
		dly_cnt_d = dly_cnt_q;  dly_bits_d = dly_bits_q;
		mrd_d = 1'b0;  mwr_d = 1'b0;  run_d = 1'b0;  entry_d = 1'b0;  brk_set = 1'b0;
		rd_pend_d = mrd_q;
		push_v    = rx_done_q && (ctl_st_q != C_OFF);
		push_data = rx_data_q;
		illegal_d = exec_flash_in && mon_q && !sec_ok_q;
		vec_d     = vec_addr_in;
		if (mon_q && vec_addr_in[15:8] == VEC_USER_PAGE && vec_addr_in[7:2] == VEC_LOW_TOP) begin
			vec_d[15:8] = VEC_MON_PAGE;
		end
		if (por_pend_q && ext_reset_n_in && !rstn_prev_q) begin
			mon_d      = test_high_voltage_in || reset_vec_blank_in;
			forced_d   = !test_high_voltage_in && reset_vec_blank_in;
			baud_d     = test_high_voltage_in && baud_select_pin_in;
			entry_d    = mon_d;
			por_pend_d = 1'b0;
		end
		case (ctl_st_q)
			C_OFF: begin
				if (mon_q && sec_ok_q) begin
					brk_set  = 1'b1;
					ctl_st_d = C_CMD;
				end else if (mon_q) begin
					ctl_st_d  = C_SEC;
					sec_idx_d = 3'h0;
					match_d   = 1'b1;
				end
			end
			C_SEC: begin
				if (rx_done_q) begin
					wdat_d  = rx_data_q;
					mrd_d   = 1'b1;
					maddr_d = SEC_BASE + {13'h0000, sec_idx_q};
				end
				if (rd_pend_q) begin
					match_d   = match_q && (mem_rdata_in == wdat_q);
					sec_idx_d = sec_idx_q + 3'h1;
					if (sec_idx_q == SEC_LAST) begin
						if (match_d) begin
							sec_ok_d = 1'b1;
							ctl_st_d = C_SECW;
							step_d   = 2'h0;
						end else begin
							brk_set  = 1'b1;
							ctl_st_d = C_CMD;
						end
					end
				end
			end
			C_SECW: begin
				if (step_q == 2'h0) begin
					mrd_d   = 1'b1;
					maddr_d = SEC_RAM_ADDR;
					step_d  = 2'h1;
				end else if (rd_pend_q) begin
					mwr_d    = 1'b1;
					mwdata_d = mem_rdata_in | (8'h01 << SEC_RAM_BIT);
					brk_set  = 1'b1;
					ctl_st_d = C_CMD;
				end
			end
			C_CMD: begin
				if (rx_done_q) begin
					cmd_d = rx_data_q;
					dly_cnt_d  = bit_len_f(baud_q);
					dly_bits_d = DLY_BITS;
					case (rx_data_q)
						CMD_READ: begin
							argn_d   = 2'h2;
							ctl_st_d = C_ARG;
						end
						CMD_WRITE: begin
							argn_d   = 2'h3;
							ctl_st_d = C_ARG;
						end
						CMD_INDEXED_WRITE_CMD: begin
							argn_d   = 2'h1;
							ctl_st_d = C_ARG;
						end
						CMD_INDEXED_READ_CMD, CMD_STACK_POINTER_READ_CMD, CMD_RUN: ctl_st_d = C_DLY;
						default: ctl_st_d = C_CMD;
					endcase
				end
			end
			C_ARG: begin
				if (rx_done_q) begin
					if (cmd_q == CMD_INDEXED_WRITE_CMD || (cmd_q == CMD_WRITE && argn_q == 2'h1)) begin
						wdat_d = rx_data_q;
					end else begin
						addr_d = {addr_q[7:0], rx_data_q};
					end
					argn_d = argn_q - 2'h1;
					if (argn_q == 2'h1) begin
						ctl_st_d   = C_DLY;
						dly_cnt_d  = bit_len_f(baud_q);
						dly_bits_d = DLY_BITS;
					end
				end
			end
			C_DLY: begin
				if (dly_cnt_q != 10'h000) begin
					dly_cnt_d = dly_cnt_q - 10'h001;
				end else begin
					dly_cnt_d  = bit_len_f(baud_q);
					dly_bits_d = dly_bits_q - 4'h1;
					if (dly_bits_q == 4'h1) begin
						ctl_st_d = C_EXEC;
					end
				end
			end
			C_EXEC: begin
				step_d   = 2'h0;
				ctl_st_d = C_MEM;
				case (cmd_q)
					CMD_READ: cnt_d = 2'h1;
					CMD_INDEXED_READ_CMD, CMD_STACK_POINTER_READ_CMD: cnt_d = 2'h2;
					CMD_WRITE, CMD_INDEXED_WRITE_CMD: begin
						mwr_d    = 1'b1;
						maddr_d  = addr_q;
						mwdata_d = wdat_q;
						addr_d   = addr_q + 16'h0001;
						ctl_st_d = C_CMD;
					end
					CMD_RUN: begin
						run_d    = 1'b1;
						ctl_st_d = C_CMD;
					end
					default: ctl_st_d = C_CMD;
				endcase
			end
			C_MEM: begin
				case (step_q)
					2'h0: begin
						if (cnt_q == 2'h0) begin
							ctl_st_d = C_CMD;
						end else if (cmd_q == CMD_STACK_POINTER_READ_CMD) begin
							hold_d = (cnt_q == 2'h2) ? sp_plus1[15:8] : sp_plus1[7:0];
							step_d = 2'h2;
						end else begin
							mrd_d   = 1'b1;
							maddr_d = addr_q;
							step_d  = 2'h1;
						end
					end
					2'h1: begin
						if (rd_pend_q) begin
							hold_d = rdata_vis;
							step_d = 2'h2;
						end
					end
					default: begin
						// An echo owns the queue input in its cycle; data waits one cycle.
						if (!rx_done_q && fifo_in_rdy) begin
							push_v    = 1'b1;
							push_data = hold_q;
							cnt_d     = cnt_q - 2'h1;
							step_d    = 2'h0;
							if (cmd_q != CMD_STACK_POINTER_READ_CMD) begin
								addr_d = addr_q + 16'h0001;
							end
						end
					end
				endcase
			end
			default: ctl_st_d = C_OFF;
		endcase
		if (rx_brk_q && (ctl_st_q == C_CMD || ctl_st_q == C_ARG || ctl_st_q == C_DLY)) begin
			brk_set  = 1'b1;
			ctl_st_d = C_CMD;
		end
		brk_req_d = brk_set || (brk_req_q && !brk_ack);
		if (user_reset_in) begin
			ctl_st_d  = C_OFF;
			brk_req_d = 1'b0;
			push_v    = 1'b0;
		end
	end

	// Only the power-on reset clears the bypass and the entry latch.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mon_q <= 1'b0;  forced_q <= 1'b0;  baud_q <= 1'b0;
			por_pend_q <= 1'b1;  rstn_prev_q <= 1'b0;
			sec_ok_q <= 1'b0;  match_q <= 1'b0;  sec_idx_q <= '0;
			ctl_st_q <= C_OFF;  cmd_q <= '0;  wdat_q <= '0;  hold_q <= '0;
			argn_q <= '0;  cnt_q <= '0;  step_q <= '0;  addr_q <= '0;
			maddr_q <= '0;  mwdata_q <= '0;  mrd_q <= 1'b0;  mwr_q <= 1'b0;
			rd_pend_q <= 1'b0;  dly_cnt_q <= '0;  dly_bits_q <= '0;
			brk_req_q <= 1'b0;  entry_q <= 1'b0;  run_q <= 1'b0;
			illegal_q <= 1'b0;  vec_q <= '0;
		end else begin
			mon_q <= mon_d;  forced_q <= forced_d;  baud_q <= baud_d;
			por_pend_q <= por_pend_d;  rstn_prev_q <= rstn_prev_d;
			sec_ok_q <= sec_ok_d;  match_q <= match_d;  sec_idx_q <= sec_idx_d;
			ctl_st_q <= ctl_st_d;  cmd_q <= cmd_d;  wdat_q <= wdat_d;  hold_q <= hold_d;
			argn_q <= argn_d;  cnt_q <= cnt_d;  step_q <= step_d;  addr_q <= addr_d;
			maddr_q <= maddr_d;  mwdata_q <= mwdata_d;  mrd_q <= mrd_d;  mwr_q <= mwr_d;
			rd_pend_q <= rd_pend_d;  dly_cnt_q <= dly_cnt_d;  dly_bits_q <= dly_bits_d;
			brk_req_q <= brk_req_d;  entry_q <= entry_d;  run_q <= run_d;
			illegal_q <= illegal_d;  vec_q <= vec_d;
		end
	end
endmodule

// ---- swmp_properties.sv ----
/* Pin checks for swmp_top. Assumes a bind in the bench. */
`timescale 1ns/1ns
module swmp_checker (
	input wire logic        mclk_in,
	input wire logic        rst_in,
	input wire logic        serial_comm_pin_out,
	input wire logic        serial_comm_pin_oe_out,
	input wire logic [15:0] vec_addr_in,
	input wire logic [15:0] vec_addr_out,
	input wire logic        mem_rd_out,
	input wire logic        entry_swi_out,
	input wire logic        monitor_mode_out,
	input wire logic        exec_flash_in,
	input wire logic        illegal_reset_out,
	input wire logic        sec_bypass_out
);
	logic [11:0] len_q;
	logic [11:0] len_d;
	logic        oe_q;
	// Counts how long the drive has held, so a bit cut short is seen.
	always_comb len_d = (serial_comm_pin_oe_out != oe_q) ? 12'h001 : len_q + 12'(len_q != 12'hFFF);
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			len_q <= 12'h000;
			oe_q  <= 1'b0;
		end else begin
			len_q <= len_d;
			oe_q  <= serial_comm_pin_oe_out;
		end
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	sequence s_pulse(sig); sig ##1 !sig; endsequence
	property p_vec; monitor_mode_out && vec_addr_in == 16'hFFFE |=> vec_addr_out == 16'hFEFE;
	endproperty
	a_vec: assert property (p_vec) else $error("vector kept");
	property p_low; serial_comm_pin_oe_out |-> !serial_comm_pin_out; endproperty
	a_low: assert property (p_low) else $error("line driven high");
	property p_bit; $changed(serial_comm_pin_oe_out) |-> len_q >= 12'h100; endproperty
	a_bit: assert property (p_bit) else $error("bit too short");
	property p_rd; mem_rd_out |-> s_pulse(mem_rd_out); endproperty
	a_rd: assert property (p_rd) else $error("read strobe long");
	property p_swi; entry_swi_out |=> !entry_swi_out && monitor_mode_out; endproperty
	a_swi: assert property (p_swi) else $error("entry pulse bad");
	property p_ill; exec_flash_in && monitor_mode_out && !sec_bypass_out |=> illegal_reset_out;
	endproperty
	a_ill: assert property (p_ill) else $error("no illegal reset");
	property p_byp; sec_bypass_out |=> sec_bypass_out; endproperty
	a_byp: assert property (p_byp) else $error("bypass lost");
	property p_mode; monitor_mode_out |=> monitor_mode_out; endproperty
	a_mode: assert property (p_mode) else $error("mode lost");
endmodule

// ---- swmp_host.sv ----
/* Host model on the shared line. Assumes an external pull-up on that line. */
`timescale 1ns/1ns
module swmp_host (
	input  wire logic line_in,
	output logic      pull_out
);
	logic [7:0] rx_q[$];
	int         n_brk = 0;
	logic       busy = 1'b0;
	logic [8:0] s;
	initial pull_out = 1'b0;
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		busy = 1'b1;
		for (int i = 0; i < 10; i++) begin
			pull_out = !f[i];
			#5120;
		end
		busy = 1'b0;
	endtask
	// Own characters are ignored, since the line is shared both ways.
	always begin
		@(negedge line_in);
		if (!busy) begin
			#2560;
			for (int i = 0; i < 9; i++) begin
				#5120;
				s[i] = line_in;
			end
			if (s == 9'h000) n_brk++;
			else rx_q.push_back(s[7:0]);
		end
	end
endmodule

// ---- single_wire_monitor_port_bench.sv ----
/* Bench for swmp_top with host and memory models. Assumes the checker file. */
`timescale 1ns/1ns
module single_wire_monitor_port_bench
	import swmp_pkg::*;
;
	logic        mclk_in = 1'b0, rst_in = 1'b1, test_high_voltage_in = 1'b1, exec_flash_in = 1'b0;
	logic        mem_is_flash_in = 1'b0, pull, user_reset_in = 1'b0, reset_vec_blank_in = 1'b0;
	logic [15:0] vec_addr_in = 16'h0000, mem_addr_out, vec_addr_out;
	logic [7:0]  mem_rdata_in = 8'h00, mem_wdata_out, mem[0:65535];
	logic        serial_comm_pin_out, serial_comm_pin_oe_out, mem_rd_out, mem_wr_out, run_out;
	logic        illegal_reset_out, entry_swi_out, monitor_mode_out, forced_div4_out, sec_bypass_out;
	int          fails = 0, n_tests = 0, cyc = 0, n_run = 0;
	wire         serial_comm_pin_in = !(serial_comm_pin_oe_out || pull);
	swmp_top DUT (.mclk_in, .rst_in, .user_reset_in, .ext_reset_n_in(1'b1),
		.test_high_voltage_in, .reset_vec_blank_in, .baud_select_pin_in(1'b0),
		.serial_comm_pin_in, .serial_comm_pin_out, .serial_comm_pin_oe_out, .mem_addr_out,
		.mem_wdata_out, .mem_rd_out, .mem_wr_out, .mem_rdata_in, .mem_is_flash_in,
		.cpu_sp_in(16'h00F0), .vec_addr_in, .vec_addr_out, .exec_flash_in, .illegal_reset_out,
		.entry_swi_out, .run_out, .monitor_mode_out, .forced_div4_out, .sec_bypass_out);
	swmp_host host (.line_in(serial_comm_pin_in), .pull_out(pull));
	always #10 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		if (mem_wr_out) mem[mem_addr_out] <= mem_wdata_out;
		mem_rdata_in <= #1 mem[mem_addr_out];
		mem_is_flash_in <= #1 mem_addr_out[15];
		if (run_out) n_run++;
		cyc++;
		if (cyc == 96000) begin
			fails++;
			tally_and_finish();
		end
	end
	task tally_and_finish;
		$display("fails %0d n_tests %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task get(input logic [7:0] exp);
		for (int i = 0; i < 8192 && host.rx_q.size() == 0; i++) @(posedge mclk_in);
		chk(host.rx_q.size() ? host.rx_q.pop_front() : 8'hxx, exp);
	endtask
	task xfer(input logic [7:0] b);
		#1 host.send(b);
		get(b);
		repeat (384) @(posedge mclk_in);
	endtask
	task t_entry;
		repeat (4) @(posedge mclk_in);
		#1 test_high_voltage_in = 1'b0;
		vec_addr_in = 16'hFFFE;
		repeat (2) @(posedge mclk_in);
		#1 chk(vec_addr_out, 16'hFEFE);
		vec_addr_in = 16'hFFFC;
		exec_flash_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1 chk(vec_addr_out, 16'hFEFC);
		chk(illegal_reset_out, 1'b1);
		chk(monitor_mode_out, 1'b1);
		chk(forced_div4_out, 1'b0);
		exec_flash_in = 1'b0;
	endtask
	task t_security;
		for (int i = 0; i < 8; i++) begin
			if (i == 7) chk(host.n_brk, 0);
			xfer(8'hA0 + 8'(i));
		end
		for (int i = 0; i < 8192 && host.n_brk == 0; i++) @(posedge mclk_in);
		#1 chk(host.n_brk, 1);
		chk(sec_bypass_out, 1'b1);
		chk(mem[16'h0040], 8'h45);
		exec_flash_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1 chk(illegal_reset_out, 1'b0);
		exec_flash_in = 1'b0;
		repeat (512) @(posedge mclk_in);
	endtask
	task t_read;
		xfer(CMD_READ);
		xfer(8'hFF);
		xfer(8'hF7);
		get(8'hA1);
		repeat (256) @(posedge mclk_in);
		xfer(CMD_INDEXED_READ_CMD);
		get(8'hA2);
		get(8'hA3);
		repeat (384) @(posedge mclk_in);
		xfer(CMD_RUN);
		chk(n_run, 1);
	endtask
	// A user reset keeps the bypass; a later power-on reset drops it and re-enters forced.
	task t_resets;
		#1 user_reset_in = 1'b1;
		@(posedge mclk_in);
		#1 user_reset_in = 1'b0;
		for (int i = 0; i < 4096 && host.n_brk < 2; i++) @(posedge mclk_in);
		#1 chk(host.n_brk, 2);
		chk(sec_bypass_out, 1'b1);
		repeat (256) @(posedge mclk_in);
		#1 rst_in = 1'b1;
		reset_vec_blank_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1 rst_in = 1'b0;
		repeat (2) @(posedge mclk_in);
		#1 chk(sec_bypass_out, 1'b0);
		chk(forced_div4_out, 1'b1);
		chk(monitor_mode_out, 1'b1);
	endtask
	initial begin
		for (int i = 0; i < 8; i++) mem[16'hFFF6 + 16'(i)] = 8'hA0 + 8'(i);
		mem[16'h0040] = 8'h05;
		repeat (2) @(posedge mclk_in);
		#1 rst_in = 1'b0;
		t_entry();
		t_security();
		t_read();
		t_resets();
		tally_and_finish();
	end
endmodule
bind swmp_top swmp_checker u_chk (.mclk_in, .rst_in, .serial_comm_pin_out, .serial_comm_pin_oe_out,
	.vec_addr_in, .vec_addr_out, .mem_rd_out, .entry_swi_out, .monitor_mode_out, .exec_flash_in,
	.illegal_reset_out, .sec_bypass_out);
